// *** logic/addr_vec_pkg.sv ***
/*
 address and vector select constants for the two bus sections.
 assumes an 18-bit host bus address and a 9-bit vector on data bits 8..0.
*/
package addr_vec_pkg;
   localparam int ADDR_W = 18;
   localparam int VEC_W = 9;
   localparam int SEL_LO = 3;
   localparam int SEL_HI = 12;
   localparam int SEL_W = SEL_HI - SEL_LO + 1;
   localparam int DATA_WIN_LSB = 5;
   localparam int CTRL_WIN_LSB = 3;
   localparam int DVEC_LO = 3;
   localparam int DVEC_HI = 8;
   localparam int CVEC_LO = 2;
   localparam int CVEC_HI = 8;
   localparam int VSEL_BIT = 2;
   localparam int DATA_LEVEL_DEFAULT = 5;
   localparam int DATA_LEVEL_ALT = 6;
   localparam int CTRL_LEVEL = 4;
   localparam logic [2:0] LVL_FIELD_W = 3'h3;
   localparam logic [VEC_W-1:0] VEC_RESET = 9'h000;
   localparam logic [4:0] TOP_PAGE = 5'h1F;
   localparam int PAGE_LSB = 13;

   typedef enum logic [1:0] {
      ARB_IDLE = 2'h0,
      ARB_REQ = 2'h1,
      ARB_VEC = 2'h3
   } arb_state_t;
endpackage

// *** logic/sel_if.sv ***
/*
 carrier for the decoded selections between decode and the select outputs.
 assumes one clock shared by all users.
*/
interface sel_if;
   logic data_hit;
   logic ctrl_hit;
   modport src (output data_hit, output ctrl_hit);
   modport dst (input data_hit, input ctrl_hit);
endinterface

// *** logic/addr_match.sv ***
/*
 address window decode for both sections.
 assumes switch inputs already synchronised; a set switch selects a zero.
*/
module addr_match
   import addr_vec_pkg::*;
(
   // bus address
   input wire logic [ADDR_W-1:0] addr,
   input wire logic access,
   // settings, 1 = switch on / jumper in
   input wire logic [SEL_W-1:0] data_sel_on,
   input wire logic [SEL_W-1:0] ctrl_sel_on,
   // result
   sel_if.src sel
);
   logic data_bits_ok;
   logic ctrl_bits_ok;
   logic page_ok;

   // data section has no bit 3 selection: it spans a 32-byte window
   always_comb begin
      page_ok = (addr[ADDR_W-1:PAGE_LSB] == TOP_PAGE);
      data_bits_ok = (addr[SEL_HI:DATA_WIN_LSB] == ~data_sel_on[SEL_W-1:DATA_WIN_LSB-SEL_LO]);
      ctrl_bits_ok = (addr[SEL_HI:CTRL_WIN_LSB] == ~ctrl_sel_on);
   end

   // data section must match bit 3 = 0; the control unit takes bit 3 from its switch
   assign sel.data_hit = access && page_ok && data_bits_ok && !addr[CTRL_WIN_LSB];
   assign sel.ctrl_hit = access && page_ok && ctrl_bits_ok;
endmodule

// *** logic/bus_addr_vector_select.sv ***
/*
 bus address decode and interrupt vector generation for a two-section
 communications multiplexer. assumes static settings from switches and
 jumpers (synchronised here) and a host that grants one request at a time.
*/
// Functional notes
// - data section base on a 32-byte boundary
// - set switch selects zero in bits 3..12
// - control unit decodes bit 3 by switch, data needs bit 3 zero
// - each section has own address and vector
// - data vector bits 8..3 from switches
// - vector select bit 0 receive, 1 transmit
// - control vector bits 8..2 from jumpers
// - vector on data 8..0, bits 1..0 zero
// - control level 4, data level 5 or 6
module bus_addr_vector_select
   import addr_vec_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // bus address side
   input wire logic [addr_vec_pkg::ADDR_W-1:0] addr,
   input wire logic access,
   output logic data_select,
   output logic ctrl_select,
   // static settings, pins
   input wire logic [addr_vec_pkg::SEL_W-1:0] data_sel_on,
   input wire logic [addr_vec_pkg::SEL_W-1:0] ctrl_sel_on,
   input wire logic [addr_vec_pkg::DVEC_HI-addr_vec_pkg::DVEC_LO:0] data_vec_on,
   input wire logic [addr_vec_pkg::CVEC_HI-addr_vec_pkg::CVEC_LO:0] ctrl_vec_on,
   input wire logic data_level_alt,
   // interrupt events from the sections
   input wire logic rx_req,
   input wire logic tx_req,
   input wire logic ctrl_req,
   // interrupt bus side
   output logic [2:0] data_level,
   output logic [2:0] ctrl_level,
   output logic data_irq,
   output logic ctrl_irq,
   input wire logic grant,
   output logic vec_valid,
   output logic [addr_vec_pkg::VEC_W-1:0] vec
);
   import addr_vec_pkg::*;

   localparam int DV_W = DVEC_HI - DVEC_LO + 1;
   localparam int CV_W = CVEC_HI - CVEC_LO + 1;
   localparam int SW_W = 2 * SEL_W + DV_W + CV_W + 1;

   ////////////////////////////////////////////////////////////////////
   // settings synchroniser: pins, two flops before use
   logic [SW_W-1:0] sw_meta, sw_sync, next_sw_meta, next_sw_sync;
   logic [SEL_W-1:0] data_sel_s, ctrl_sel_s;
   logic [DV_W-1:0] dvec_s;
   logic [CV_W-1:0] cvec_s;
   logic alt_s;

   always_comb begin
      next_sw_meta = {data_sel_on, ctrl_sel_on, data_vec_on, ctrl_vec_on, data_level_alt};
      next_sw_sync = sw_meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_meta <= '0;
         sw_sync <= '0;
      end else begin
         sw_meta <= next_sw_meta;
         sw_sync <= next_sw_sync;
      end
   end

   assign {data_sel_s, ctrl_sel_s, dvec_s, cvec_s, alt_s} = sw_sync;

   ////////////////////////////////////////////////////////////////////
   // address decode
   sel_if sel ();

   addr_match u_match (
      .addr(addr),
      .access(access),
      .data_sel_on(data_sel_s),
      .ctrl_sel_on(ctrl_sel_s),
      .sel(sel)
   );

   assign data_select = sel.data_hit;
   assign ctrl_select = sel.ctrl_hit;

   ////////////////////////////////////////////////////////////////////
   // request levels
   assign ctrl_level = 3'(CTRL_LEVEL);
   assign data_level = alt_s ? 3'(DATA_LEVEL_ALT) : 3'(DATA_LEVEL_DEFAULT);

   ////////////////////////////////////////////////////////////////////
   // arbiter and pending flags
   logic rx_pend, tx_pend, ctrl_pend;
   logic next_rx_pend, next_tx_pend, next_ctrl_pend;
   arb_state_t state, next_state;
   logic [VEC_W-1:0] next_vec;
   logic served_data, served_tx, next_served_data, next_served_tx;
   logic take_grant;
   logic vector_select_bit;

   ////////////////////////////////////////////////////////////////////
   // assembled vectors, bit by bit; switch on means a zero bit
   wire logic [VEC_W-1:0] data_vec_rx, data_vec_tx, ctrl_vec;

   for (genvar b = 0; b < VEC_W; b++) begin : g_vec_bit
      if (b >= DVEC_LO) begin : g_data_sw
         assign data_vec_rx[b] = ~dvec_s[b-DVEC_LO];
         assign data_vec_tx[b] = ~dvec_s[b-DVEC_LO];
      end else if (b == VSEL_BIT) begin : g_data_sel
         assign data_vec_rx[b] = 1'b0;
         assign data_vec_tx[b] = 1'b1;
      end else begin : g_data_low
         assign data_vec_rx[b] = 1'b0;
         assign data_vec_tx[b] = 1'b0;
      end
      if (b >= CVEC_LO) begin : g_ctrl_jp
         assign ctrl_vec[b] = ~cvec_s[b-CVEC_LO];
      end else begin : g_ctrl_low
         assign ctrl_vec[b] = 1'b0;
      end
   end

   // receive outranks transmit, so the select bit stays low while receive waits
   assign vector_select_bit = !rx_pend;
   // a grant only counts while a request line is raised
   assign take_grant = (state == ARB_REQ) && grant;

   ////////////////////////////////////////////////////////////////////
   // pending flags; a request in the grant cycle wins over the clear
   always_comb begin
      next_rx_pend = rx_pend;
      next_tx_pend = tx_pend;
      next_ctrl_pend = ctrl_pend;
      if (take_grant) begin
         if (!served_data)
            next_ctrl_pend = 1'b0;
         else if (served_tx)
            next_tx_pend = 1'b0;
         else
            next_rx_pend = 1'b0;
      end
      if (rx_req)
         next_rx_pend = 1'b1;
      if (tx_req)
         next_tx_pend = 1'b1;
      if (ctrl_req)
         next_ctrl_pend = 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_pend <= 1'b0;
         tx_pend <= 1'b0;
         ctrl_pend <= 1'b0;
      end else begin
         rx_pend <= next_rx_pend;
         tx_pend <= next_tx_pend;
         ctrl_pend <= next_ctrl_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // arbiter: one request on the bus at a time

   always_comb begin
      next_state = state;
      next_vec = vec;
      next_served_data = served_data;
      next_served_tx = served_tx;
      case (state)
         ARB_IDLE: begin
            // data section outranks the control unit by level
            if (rx_pend || tx_pend) begin
               next_served_data = 1'b1;
               next_served_tx = vector_select_bit;
               next_vec = vector_select_bit ? data_vec_tx : data_vec_rx;
               next_state = ARB_REQ;
            end else if (ctrl_pend) begin
               next_served_data = 1'b0;
               next_served_tx = 1'b0;
               next_vec = ctrl_vec;
               next_state = ARB_REQ;
            end
         end
         ARB_REQ: begin
            if (take_grant)
               next_state = ARB_VEC;
         end
         ARB_VEC: begin
            next_state = ARB_IDLE;
         end
         default: begin
            next_state = ARB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ARB_IDLE;
         vec <= VEC_RESET;
         served_data <= 1'b0;
         served_tx <= 1'b0;
      end else begin
         state <= next_state;
         vec <= next_vec;
         served_data <= next_served_data;
         served_tx <= next_served_tx;
      end
   end

   // separate request lines per section
   assign data_irq = (state == ARB_REQ) && served_data;
   assign ctrl_irq = (state == ARB_REQ) && !served_data;
   assign vec_valid = (state == ARB_VEC);
endmodule

// *** dv/bus_addr_vector_select_chk.sv ***
/*
 port checker for the address decode and vector block.
 assumes settings are held a few cycles before they are relied on.
*/
module bus_addr_vector_select_chk
   import addr_vec_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // watched ports
   input wire logic [addr_vec_pkg::ADDR_W-1:0] addr,
   input wire logic access,
   input wire logic data_select,
   input wire logic ctrl_select,
   input wire logic [addr_vec_pkg::SEL_W-1:0] data_sel_on,
   input wire logic [addr_vec_pkg::SEL_W-1:0] ctrl_sel_on,
   input wire logic [5:0] data_vec_on,
   input wire logic [6:0] ctrl_vec_on,
   input wire logic data_level_alt,
   input wire logic [2:0] data_level,
   input wire logic [2:0] ctrl_level,
   input wire logic data_irq,
   input wire logic ctrl_irq,
   input wire logic grant,
   input wire logic vec_valid,
   input wire logic [addr_vec_pkg::VEC_W-1:0] vec
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] up;
   logic [1:0] next_up;
   logic [33:0] cfg;
   assign cfg = {data_sel_on, ctrl_sel_on, data_vec_on, ctrl_vec_on, data_level_alt};
   always_comb next_up = (up == 2'h3) ? up : up + 2'h1;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) up <= 2'h0;
      else up <= next_up;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////
   // settings pass two sync stages, so judge only once they are through
   sequence s_calm; up == 2'h3 && $past(cfg, 3) == cfg && $past(cfg) == cfg; endsequence
   sequence s_grant; (data_irq || ctrl_irq) && grant; endsequence
   sequence s_pulse; vec_valid && !data_irq && !ctrl_irq ##1 !vec_valid; endsequence
   a_data_decode: assert property (
      s_calm |-> data_select == (access && addr[17:13] == 5'h1F
         && addr[12:5] == ~data_sel_on[9:2] && !addr[3])) else $error("data decode wrong");
   a_ctrl_decode: assert property (
      s_calm |-> ctrl_select == (access && addr[17:13] == 5'h1F && addr[12:3] == ~ctrl_sel_on))
      else $error("control decode wrong");
   a_idle_quiet: assert property (!access |-> !data_select && !ctrl_select)
      else $error("select without access");
   a_vec_align: assert property (vec_valid |-> vec[1:0] == 2'h0)
      else $error("vector low bits set");
   a_data_vec: assert property (s_calm ##0 data_irq |-> vec[8:3] == ~data_vec_on)
      else $error("data vector wrong");
   a_ctrl_vec: assert property (s_calm ##0 ctrl_irq |-> vec[8:2] == ~ctrl_vec_on)
      else $error("control vector wrong");
   a_irq_levels: assert property (
      s_calm |-> ctrl_level == 3'h4 && data_level == (data_level_alt ? 3'h6 : 3'h5))
      else $error("request level wrong");
   a_grant_pulse: assert property (s_grant |=> s_pulse)
      else $error("vector pulse wrong");
   a_vec_steady: assert property (data_irq && $past(data_irq) |-> $stable(vec))
      else $error("vector moved while pending");
endmodule
bind bus_addr_vector_select bus_addr_vector_select_chk chk_inst (.*);

// *** dv/host_model.sv ***
/*
 host model: grants a pending interrupt after a set latency.
 assumes one level request line, high while a vector waits.
*/
module host_model (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // interrupt handshake
   input wire logic irq,
   input wire logic [1:0] lat,
   output logic grant
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 2'h0;
         grant <= 1'b0;
      end else begin
         // one-cycle grant, so a request is never taken twice
         grant <= irq && !grant && cnt == lat;
         cnt <= (irq && !grant && cnt != lat) ? cnt + 2'h1 : 2'h0;
      end
   end
endmodule

// *** dv/bus_addr_vector_select_tb.sv ***
/*
 self-checking bench for the address decode and vector block.
 assumes the checker is bound from its own file.
*/
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end
module bus_addr_vector_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import addr_vec_pkg::*;
   logic clk = 0, arst_n = 0, access = 0, alt = 0, rx = 0, tx = 0, cr = 0;
   logic grant, dsel, csel, dirq, cirq, vv;
   logic [17:0] addr = 18'h0, a;
   logic [9:0] ds = 10'h0, cs = 10'h0;
   logic [5:0] dv = 6'h0;
   logic [6:0] cv = 7'h0;
   logic [2:0] dl, cl, r;
   logic [8:0] vec, v;
   logic [1:0] lat = 2'h0;
   int n_errors = 0, total_checks = 0, seed = 86479, cyc = 0;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin n_errors++; report_and_stop(); end
   end
   bus_addr_vector_select bus_addr_vector_select_inst (.clk(clk), .arst_n(arst_n),
      .addr(addr), .access(access), .data_select(dsel), .ctrl_select(csel), .data_sel_on(ds),
      .ctrl_sel_on(cs), .data_vec_on(dv), .ctrl_vec_on(cv), .data_level_alt(alt), .rx_req(rx),
      .tx_req(tx), .ctrl_req(cr), .data_level(dl), .ctrl_level(cl), .data_irq(dirq),
      .ctrl_irq(cirq), .grant(grant), .vec_valid(vv), .vec(vec));
   host_model host_model_inst (.clk(clk), .arst_n(arst_n), .irq(dirq | cirq), .lat(lat),
      .grant(grant));
   ////////////////////////////////////////////////////////////////////
   function automatic logic exp_data(logic [17:0] x, logic [9:0] s);
      return x[17:13] == 5'h1F && x[12:5] == ~s[9:2] && !x[3];
   endfunction
   function automatic logic exp_ctrl(logic [17:0] x, logic [9:0] s);
      return x[17:13] == 5'h1F && x[12:3] == ~s;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic take_vec(logic [8:0] e, logic c);
      int k = 0;
      while (dirq !== 1'b1 && cirq !== 1'b1 && k < 40) begin tick(1); k++; end
      `CHK({dirq, cirq}, {!c, c})
      while (vv !== 1'b1 && k < 40) begin tick(1); k++; end
      `CHK(vv, 1'b1)
      `CHK(vec, e)
      tick(1);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      tick(4);
      `CHK(vv, 1'b0)
      `CHK(vec, VEC_RESET)
      `CHK({dirq, cirq}, 2'h0)
      arst_n = 1'b1;
      // first pass uses the usual first-unit base pair
      for (int i = 0; i < 150; i++) begin
         ds = i ? 10'($random(seed)) : 10'h0BF;
         cs = i ? 10'($random(seed)) : 10'h0BD;
         tick(3);
         for (int j = 0; j < 3; j++) begin
            a = j == 0 ? {5'h1F, ~ds[9:2], 5'($random(seed))} :
               j == 1 ? {5'h1F, ~cs, 3'($random(seed))} : 18'($random(seed));
            addr = a;
            access = 1'($random(seed));
            #1 `CHK(dsel, access && exp_data(a, ds))
            `CHK(csel, access && exp_ctrl(a, cs))
            tick(1);
         end
      end
      access = 1'b0;
      for (int i = 0; i < 60; i++) begin
         v = {3'(3 + $unsigned($random(seed)) % 5), 6'($random(seed))};
         dv = ~v[8:3];
         cv = ~{v[8:6], 4'($random(seed))};
         alt = 1'($random(seed));
         lat = 2'($random(seed));
         r = 3'($random(seed));
         if (r == 3'h0) r = 3'h7;
         tick(3);
         `CHK(dl, alt ? 3'h6 : 3'h5)
         `CHK(cl, 3'h4)
         {cr, tx, rx} = r;
         tick(1);
         {cr, tx, rx} = 3'h0;
         if (r[0]) take_vec({v[8:3], 3'h0}, 1'b0);
         if (r[1]) take_vec({v[8:3], 3'h4}, 1'b0);
         if (r[2]) take_vec({~cv, 2'h0}, 1'b1);
      end
      report_and_stop();
   end
endmodule
